// File: verilog/laser_sup_pkg.sv
// Package with constants, register map and types for the laser run supervisor
package laser_sup_pkg;

    localparam int unsigned ADDR_W = 4;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] CTRL_OFF   = 4'h0;
    localparam logic [ADDR_W-1:0] STATUS_OFF = 4'h4;
    localparam logic [ADDR_W-1:0] IRQ_OFF    = 4'h8;
    localparam logic [ADDR_W-1:0] MASK_OFF   = 4'hC;

    // Control fields
    localparam int unsigned CTRL_DUTY_LIMIT_LSB = 0;
    localparam int unsigned CTRL_DUTY_LIMIT_W   = 8;
    localparam int unsigned CTRL_WINDOW_LSB     = 8;
    localparam int unsigned CTRL_WINDOW_W       = 8;
    localparam logic [7:0]  DUTY_LIMIT_RST      = 8'h80;
    localparam logic [7:0]  WINDOW_RST          = 8'hFF;

    // Interrupt event bit positions
    localparam int unsigned EV_LATCH   = 0;
    localparam int unsigned EV_TERM    = 1;
    localparam int unsigned EV_DUTY    = 2;
    localparam int unsigned EV_REFLECT = 3;
    localparam int unsigned EV_RECOVER = 4;
    localparam int unsigned EV_W       = 5;
    localparam logic [EV_W-1:0] MASK_RST = 5'h00;

    // Cycles the latching shutdown may take to show on the summary line
    localparam int unsigned CLK_MHZ         = 25;
    localparam int unsigned FAULT_REPORT_US = 1;
    localparam int unsigned FAULT_REPORT_CYC = FAULT_REPORT_US * CLK_MHZ;

    // Last count of the power-up self check (nine cycles in ST_CHECK)
    localparam logic [3:0] POWERUP_CYC = 4'h8;

    typedef enum logic [1:0] {
        ST_CHECK   = 2'b00,
        ST_IDLE    = 2'b01,
        ST_RUN     = 2'b10,
        ST_LATCHED = 2'b11
    } sup_state_t;

endpackage

// File: verilog/laser_run_fault_supervisor.sv
// Run permit, pulse gating and fault classification with Wishbone registers
`timescale 1ns/1ps
module laser_run_fault_supervisor
    import laser_sup_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // Wishbone classic slave
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [ADDR_W-1:0] adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    output logic                   ack_o,
    output logic                   irq,
    // Real-time port from the machine controller
    input  wire logic              runPermit,
    input  wire logic              pulseCmd,
    // Internal condition sensors (asynchronous)
    input  wire logic              overTemp,
    input  wire logic              shutterFault,
    input  wire logic              reflectHigh,
    input  wire logic              termCondition,
    // Outputs
    output logic                   laserOn,
    output logic                   systemFault,
    output logic                   latchFaultFlag,
    output logic                   duty_excess_flag,
    output logic                   reflect_excess_flag
);

    typedef struct packed {
        logic [1:0]      permitS;
        logic [1:0]      pulseS;
        logic [1:0]      tempS;
        logic [1:0]      shutS;
        logic [1:0]      reflS;
        logic [1:0]      termS;
        sup_state_t      state;
        logic [3:0]      checkCnt;
        logic            termLatched;
        logic            permitSeen;
        logic [7:0]      winCnt;
        logic [7:0]      onCnt;
        logic [7:0]      dutyLimit;
        logic [7:0]      winLen;
        logic [EV_W-1:0] irqStat;
        logic [EV_W-1:0] irqMask;
        logic            ack;
        logic [31:0]     rdata;
        logic            laser;
        logic            sysFault;
        logic            latchOut;
        logic            dutyOut;
        logic            reflOut;
    } sup_t;

    sup_t st_reg;
    sup_t st_next;

    function automatic logic [1:0] sync2(input logic [1:0] s, input logic d);
        return {s[0], d};
    endfunction

    function automatic logic [7:0] merge8(input logic [7:0] old,
                                          input logic [7:0] nw,
                                          input logic       en);
        return en ? nw : old;
    endfunction

    logic permit;
    logic pulse;
    logic latchCond;
    logic reflActive;
    logic dutyOver;
    logic busReq;
    logic [EV_W-1:0] events;

    assign permit     = st_reg.permitS[1];
    assign pulse      = st_reg.pulseS[1];
    assign latchCond  = st_reg.tempS[1] | st_reg.shutS[1];
    assign reflActive = st_reg.reflS[1];
    assign busReq     = cyc_i & stb_i & ~st_reg.ack;
    // Duty budget spent inside the current window
    assign dutyOver   = st_reg.onCnt >= st_reg.dutyLimit;

    always_comb begin
        st_next = st_reg;
        events  = '0;

        st_next.permitS = sync2(st_reg.permitS, runPermit);
        st_next.pulseS  = sync2(st_reg.pulseS, pulseCmd);
        st_next.tempS   = sync2(st_reg.tempS, overTemp);
        st_next.shutS   = sync2(st_reg.shutS, shutterFault);
        st_next.reflS   = sync2(st_reg.reflS, reflectHigh);
        st_next.termS   = sync2(st_reg.termS, termCondition);
        st_next.permitSeen = permit;

        case (st_reg.state)
            ST_CHECK: begin
                // Power-up self check for terminal conditions
                if (st_reg.termS[1]) begin
                    st_next.termLatched = 1'b1;
                end
                if (st_reg.checkCnt == POWERUP_CYC) begin
                    st_next.state = ST_IDLE;
                    if (st_reg.termLatched | st_reg.termS[1]) begin
                        events[EV_TERM] = 1'b1;
                    end
                end else begin
                    st_next.checkCnt = st_reg.checkCnt + 4'h1;
                end
            end
            ST_IDLE: begin
                if (latchCond) begin
                    st_next.state = ST_LATCHED;
                    events[EV_LATCH] = 1'b1;
                end else if (permit & ~st_reg.termLatched) begin
                    st_next.state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (latchCond) begin
                    st_next.state = ST_LATCHED;
                    events[EV_LATCH] = 1'b1;
                end else if (~permit) begin
                    st_next.state = ST_IDLE;
                end
            end
            ST_LATCHED: begin
                // Stays halted until permit falls with the cause removed
                if (~latchCond & st_reg.permitSeen & ~permit) begin
                    st_next.state = ST_IDLE;
                    events[EV_RECOVER] = 1'b1;
                end
            end
            default: begin
                st_next.state = ST_LATCHED;
            end
        endcase

        // Duty window: pulse-on time counted per fixed window
        if (st_reg.winCnt >= st_reg.winLen) begin
            st_next.winCnt = 8'h00;
            st_next.onCnt  = 8'h00;
        end else begin
            st_next.winCnt = st_reg.winCnt + 8'h01;
            if (pulse & ~dutyOver) begin
                st_next.onCnt = st_reg.onCnt + 8'h01;
            end
        end

        // Output gating
        st_next.laser = pulse & (st_reg.state == ST_RUN) & permit
                      & ~latchCond & ~st_reg.termLatched
                      & ~dutyOver & ~reflActive;
        st_next.dutyOut = pulse & dutyOver;
        st_next.reflOut = pulse & reflActive;
        // Dedicated latching line apart from summary
        st_next.latchOut = (st_reg.state == ST_LATCHED) | latchCond;
        // Summary registered in the same cycle as shutdown
        st_next.sysFault = (st_reg.state == ST_LATCHED) | latchCond
                         | st_reg.termLatched;
        if (pulse & dutyOver & ~st_reg.dutyOut) begin
            events[EV_DUTY] = 1'b1;
        end
        if (pulse & reflActive & ~st_reg.reflOut) begin
            events[EV_REFLECT] = 1'b1;
        end

        // Wishbone slave, ack one cycle after request
        st_next.ack = busReq;
        if (busReq) begin
            st_next.rdata = 32'h0000_0000;
            case (adr_i)
                CTRL_OFF: begin
                    st_next.rdata = {16'h0000, st_reg.winLen,
                                     st_reg.dutyLimit};
                    if (we_i) begin
                        st_next.dutyLimit = merge8(st_reg.dutyLimit,
                                                   dat_i[7:0], sel_i[0]);
                        st_next.winLen = merge8(st_reg.winLen,
                                                dat_i[15:8], sel_i[1]);
                    end
                end
                STATUS_OFF: begin
                    st_next.rdata = {24'h000000, 1'b0, st_reg.termS[1],
                                     latchCond, st_reg.termLatched,
                                     reflActive, dutyOver,
                                     st_reg.state};
                end
                IRQ_OFF: begin
                    st_next.rdata = {27'h0000000, st_reg.irqStat};
                end
                MASK_OFF: begin
                    st_next.rdata = {27'h0000000, st_reg.irqMask};
                    if (we_i & sel_i[0]) begin
                        st_next.irqMask = dat_i[EV_W-1:0];
                    end
                end
                default: begin
                    st_next.rdata = 32'h0000_0000;
                end
            endcase
        end

        // Read clears status; a new event in the same cycle wins
        if (busReq & ~we_i & (adr_i == IRQ_OFF)) begin
            st_next.irqStat = events;
        end else begin
            st_next.irqStat = st_reg.irqStat | events;
        end

        if (rst) begin
            st_next          = '0;
            st_next.state    = ST_CHECK;
            st_next.dutyLimit = DUTY_LIMIT_RST;
            st_next.winLen   = WINDOW_RST;
            st_next.irqMask  = MASK_RST;
        end
    end

    always_ff @(posedge sys_clk) begin
        st_reg <= st_next;
    end

    assign dat_o               = st_reg.rdata;
    assign ack_o               = st_reg.ack;
    assign irq                 = |(st_reg.irqStat & st_reg.irqMask);
    assign laserOn             = st_reg.laser;
    assign systemFault         = st_reg.sysFault;
    assign latchFaultFlag      = st_reg.latchOut;
    assign duty_excess_flag    = st_reg.dutyOut;
    assign reflect_excess_flag = st_reg.reflOut;

endmodule // laser_run_fault_supervisor

// File: tb/laser_sup_sva.sv
// Port-level assertions for the laser run and fault supervisor
`timescale 1ns/1ps
module laser_sup_sva
    import laser_sup_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              rst,
    input wire logic              cyc_i,
    input wire logic              stb_i,
    input wire logic              we_i,
    input wire logic [ADDR_W-1:0] adr_i,
    input wire logic [3:0]        sel_i,
    input wire logic [31:0]       dat_i,
    input wire logic [31:0]       dat_o,
    input wire logic              ack_o,
    input wire logic              irq,
    input wire logic              runPermit,
    input wire logic              pulseCmd,
    input wire logic              overTemp,
    input wire logic              shutterFault,
    input wire logic              reflectHigh,
    input wire logic              termCondition,
    input wire logic              laserOn,
    input wire logic              systemFault,
    input wire logic              latchFaultFlag,
    input wire logic              duty_excess_flag,
    input wire logic              reflect_excess_flag
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    gate_pulse_a: assert property (
        laserOn |-> $past(pulseCmd, 3) && $past(runPermit, 3))
        else $error("laser on without pulse and permit");
    duty_gate_a: assert property (
        duty_excess_flag |-> $past(pulseCmd, 3))
        else $error("duty flag outside a pulse");
    reflect_gate_a: assert property (
        reflect_excess_flag |-> $past(pulseCmd, 3) && $past(reflectHigh, 3))
        else $error("reflect flag without pulse and cause");
    inhibit_off_a: assert property (
        laserOn |-> !duty_excess_flag && !reflect_excess_flag)
        else $error("laser on while inhibited");
    latch_now_a: assert property (
        $past(overTemp, 3) || $past(shutterFault, 3)
        |-> latchFaultFlag && systemFault && !laserOn)
        else $error("latching cause not shut down");
    latch_recover_a: assert property (
        $fell(latchFaultFlag) |-> !$past(runPermit, 4))
        else $error("latch cleared without permit release");
    fault_off_a: assert property (
        systemFault |-> !laserOn)
        else $error("laser on during summary fault");
    ack_once_a: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    ack_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered");

    run_c: cover property ($rose(laserOn));
    duty_c: cover property ($rose(duty_excess_flag));
    recover_c: cover property ($fell(latchFaultFlag));
endmodule // laser_sup_sva

bind laser_run_fault_supervisor laser_sup_sva i_laser_sup_sva (.*);

// File: tb/laser_ctrl_model.sv
// Machine controller model driving run permit and pulse command
`timescale 1ns/1ps
module laser_ctrl_model (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       permitReq,
    input  wire logic       pulseEn,
    input  wire logic [7:0] pulseWidth,
    output logic            runPermit,
    output logic            pulseCmd
);
    logic [7:0] phase;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            phase     <= 8'h00;
            runPermit <= 1'b0;
            pulseCmd  <= 1'b0;
        end else begin
            phase     <= phase + 8'h08; // Period of 32 cycles
            runPermit <= permitReq;
            pulseCmd  <= pulseEn && (phase < {pulseWidth[4:0], 3'h0});
        end
    end
endmodule // laser_ctrl_model

// File: tb/test_laser_run_fault_supervisor.sv
// Register and real-time port tests of the laser run supervisor
`timescale 1ns/1ps
`define CHECK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module test_laser_run_fault_supervisor;
    import laser_sup_pkg::*;
    logic              sys_clk, rst, cyc_i, stb_i, we_i, ack_o, irq, clr;
    logic [ADDR_W-1:0] adr_i;
    logic [3:0]        sel_i;
    logic [31:0]       dat_i, dat_o;
    logic              runPermit, pulseCmd, overTemp, shutterFault;
    logic              reflectHigh, termCondition, laserOn, systemFault;
    logic              latchFaultFlag, duty_excess_flag, reflect_excess_flag;
    logic              permitReq, pulseEn;
    logic [7:0]        pulseWidth;
    logic [31:0]       scratch;
    logic [2:0]        seen;
    int                fails, n_compared, cycles;

    laser_run_fault_supervisor i_laser_run_fault_supervisor (.*);
    laser_ctrl_model i_laser_ctrl_model (.*);

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        seen <= clr ? 3'h0
                    : seen | {reflect_excess_flag, duty_excess_flag, laserOn};
        cycles++;
        if (cycles == 6000) begin
            fails++;
            conclude();
        end
    end

    task automatic conclude();
        $display("compared %0d failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic ticks(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic clearSeen();
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
    endtask
    task automatic wbXfer(input logic w, input logic [ADDR_W-1:0] a,
                          input logic [31:0] d, output logic [31:0] q);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        do
            @(posedge sys_clk);
        while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        wbXfer(1'b1, a, d, q);
    endtask
    task automatic chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
        logic [31:0] q;
        wbXfer(1'b0, a, 32'h0, q);
        `CHECK(q, e)
    endtask

    initial begin
        {cyc_i, stb_i, we_i, clr, overTemp, shutterFault} = 6'h00;
        {reflectHigh, termCondition, permitReq, pulseEn} = 4'h0;
        {adr_i, dat_i, pulseWidth, fails, n_compared} = '0;
        sel_i = 4'hF;
        rst = 1'b1;
        ticks(6);
        rst <= 1'b0;
        ticks(12);
        chk(CTRL_OFF, {16'h0, WINDOW_RST, DUTY_LIMIT_RST});
        chk(MASK_OFF, 32'h0);
        chk(STATUS_OFF, 32'h1);
        chk(4'h2, 32'h0);
        wr(CTRL_OFF, 32'h0000_3F10); // Window 64 cycles, budget 16
        permitReq <= 1'b1;
        pulseWidth <= 8'h04;
        pulseEn <= 1'b1;
        clearSeen();
        ticks(200);
        `CHECK(seen, 3'h1)
        pulseWidth <= 8'h1E;
        ticks(200);
        `CHECK(seen[1], 1'b1)
        `CHECK(irq, 1'b0)
        wr(MASK_OFF, 32'h0000_001F);
        `CHECK(irq, 1'b1)
        pulseEn <= 1'b0;
        ticks(8);
        chk(IRQ_OFF, 32'h4);
        chk(IRQ_OFF, 32'h0);
        `CHECK(irq, 1'b0)
        pulseWidth <= 8'h04;
        pulseEn <= 1'b1;
        reflectHigh <= 1'b1;
        clearSeen();
        ticks(100);
        `CHECK(seen[2], 1'b1)
        reflectHigh <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            // Empty the event register so only this fault's events remain
            ticks(4);
            wbXfer(1'b0, IRQ_OFF, 32'h0, scratch);
            overTemp <= (k == 0);
            shutterFault <= (k == 1);
            ticks(5);
            `CHECK(latchFaultFlag, 1'b1)
            `CHECK(systemFault, 1'b1)
            overTemp <= 1'b0;
            shutterFault <= 1'b0;
            clearSeen();
            ticks(100);
            `CHECK(seen[0], 1'b0)
            chk(STATUS_OFF, 32'h3);
            permitReq <= 1'b0;
            ticks(10);
            permitReq <= 1'b1;
            ticks(10);
            `CHECK(latchFaultFlag, 1'b0)
            chk(STATUS_OFF, 32'h2);
            chk(IRQ_OFF, 32'h11);
        end
        permitReq <= 1'b0;
        termCondition <= 1'b1;
        rst <= 1'b1;
        ticks(6);
        rst <= 1'b0;
        ticks(14);
        permitReq <= 1'b1;
        clearSeen();
        ticks(100);
        `CHECK(systemFault, 1'b1)
        `CHECK(latchFaultFlag, 1'b0)
        `CHECK(seen[0], 1'b0)
        conclude();
    end
endmodule // test_laser_run_fault_supervisor
